// *** include/ddac_pkg.sv ***
// Package: constants and carrier types for the dual DAC two-wire slave
package ddac_pkg;
    // Slave address: fixed upper six bits, low bit from the select pin
    localparam logic [5:0] ADDR_UPPER = 6'h06;
    // Data word field positions
    localparam int MODE_HI_POS = 15;
    localparam int MODE_LO_POS = 14;
    localparam int CLEAR_POS = 13;
    localparam int LOAD_POS = 12;
    localparam int CODE_MSB_POS = 11;
    // Pointer byte field positions
    localparam int PTR_A_POS = 0;
    localparam int PTR_B_POS = 1;
    // Reset values
    localparam logic [1:0] PTR_RESET = 2'h0;
    localparam logic [15:0] DEFAULT_WORD = 16'h2000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // Power-up exit time after eighth clock of the data byte
    localparam real PD_EXIT_US = 2.5;
    localparam real CLK_MHZ = 20.0;
    localparam int PD_EXIT_CYC = int'(PD_EXIT_US * CLK_MHZ);

    // Power modes
    typedef enum logic [1:0] {
        DDAC_PM_NORMAL = 2'b00,
        DDAC_PM_1K = 2'b01,
        DDAC_PM_100K = 2'b10,
        DDAC_PM_HIZ = 2'b11
    } ddac_pmode_t;

    // One open-drain pin as two signals
    typedef struct packed {
        logic out;
        logic oe;
    } ddac_pin_drv_t;

    // Decoded data word fields
    typedef struct packed {
        ddac_pmode_t mode;
        logic clearAllN;
        logic syncLoadN;
        logic [11:0] code;
    } ddac_word_t;
endpackage

// *** core/ddac_cond_det.sv ***
// Start and stop condition detector on the bus pins
module ddac_cond_det
    import ddac_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic startSeen,
    output logic stopSeen,
    output logic sclRise,
    output logic sclFall
);
    logic sclPrev;
    logic sdaPrev;
    logic next_sclPrev;
    logic next_sdaPrev;

    // Previous pin levels; pins are synchronous to the clock
    always_comb begin
        next_sclPrev = sclIn;
        next_sdaPrev = sdaIn;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= next_sclPrev;
            sdaPrev <= next_sdaPrev;
        end
    end

    // Data moving while the clock is high marks start or stop
    assign startSeen = sclIn && sclPrev && sdaPrev && !sdaIn;
    assign stopSeen = sclIn && sclPrev && !sdaPrev && sdaIn;
    assign sclRise = sclIn && !sclPrev;
    assign sclFall = !sclIn && sclPrev;
endmodule

// *** core/ddac_channel.sv ***
// One DAC channel: input register, held register and power mode
module ddac_channel
    import ddac_pkg::*;
#(
    parameter int CODE_W = 12
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic writeEn,
    input wire logic clearAll,
    input wire logic loadAll,
    input wire ddac_word_t wordIn,
    output ddac_word_t inputWord,
    output logic [CODE_W-1:0] heldCode,
    output ddac_pmode_t powerMode
);
    ddac_word_t next_inputWord;
    logic [CODE_W-1:0] next_heldCode;
    ddac_pmode_t next_powerMode;
    logic dirty;
    logic next_dirty;

    // Clear beats write; load moves only freshly written codes
    always_comb begin
        next_inputWord = inputWord;
        next_heldCode = heldCode;
        next_powerMode = powerMode;
        next_dirty = dirty;
        if (clearAll) begin
            next_inputWord = '{DDAC_PM_NORMAL, 1'b1, 1'b1, 12'h000};
            next_heldCode = '0;
            next_dirty = 1'b0;
        end else if (writeEn) begin
            next_inputWord = wordIn;
            next_powerMode = wordIn.mode;
            next_dirty = 1'b1;
        end
        if (!clearAll && loadAll && (dirty || writeEn)) begin
            next_heldCode = next_inputWord.code[11 -: CODE_W];
            next_dirty = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            inputWord <= '{DDAC_PM_NORMAL, 1'b1, 1'b1, 12'h000};
            heldCode <= '0;
            powerMode <= DDAC_PM_NORMAL;
            dirty <= 1'b0;
        end else begin
            inputWord <= next_inputWord;
            heldCode <= next_heldCode;
            powerMode <= next_powerMode;
            dirty <= next_dirty;
        end
    end
endmodule

// *** core/ddac_slave.sv ***
// Two-wire slave command interface of the dual DAC
// Summary of operation
// - Both channel bits set: same data and control go to both channels.
// - Readback with both or no channel gives zero word with clear bit 1.
// - Write opens with address and direction 0; device acknowledges low.
// - Pointer byte then two data bytes, each acknowledged, then stop.
// - Pointer readback: repeated start, address direction 1, two bytes out.
// - Read bytes use write layout with don't-care bits as zero.
// - Master acknowledge after second byte repeats both bytes again.
// - Direct read uses the last stored pointer.
// - Input register loads only when a full write completes.
// - Load bit high keeps DAC registers unchanged.
// - Load bit low moves input to DAC registers of written channels.
// - Only channels written since the last load are updated.
// - Mode comes from data word bits 15 and 14.
// - Modes: normal, 1k to ground, 100k to ground, high impedance.
// - Power-down leaves register contents intact.
// - Power-up exit timed from eighth clock of the second data byte.
// - Respond only to own address; low bit from select pin.
// - Address upper six bits are 000110.
// - Word: mode, clear bit 13, load bit 12, left-justified code.
// - Clear bit low zeroes all input and DAC registers.
// - Pointer bit 1 selects B, bit 0 selects A.
module ddac_slave
    import ddac_pkg::*;
#(
    parameter int CODE_W = 12
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic addr_select_pin,
    output logic [CODE_W-1:0] chanACode,
    output logic [CODE_W-1:0] chanBCode,
    output ddac_pmode_t chanAMode,
    output ddac_pmode_t chanBMode,
    output logic chanAWaking,
    output logic chanBWaking
);
    // Only the three code widths fit the word layout
    if (!(CODE_W == 8 || CODE_W == 10 || CODE_W == 12)) begin : gen_bad_w
        $error("CODE_W must be 8, 10 or 12");
    end

    typedef enum logic [2:0] {
        DDAC_ST_IDLE = 3'b000,
        DDAC_ST_ADDR = 3'b001,
        DDAC_ST_PTR = 3'b011,
        DDAC_ST_DATA = 3'b010,
        DDAC_ST_READ = 3'b110,
        DDAC_ST_DONE = 3'b111
    } ddac_state_t;

    logic startSeen, stopSeen, sclRise, sclFall;
    ddac_state_t state, next_state;
    logic [7:0] shiftReg, next_shiftReg;
    logic [3:0] bitCnt, next_bitCnt;
    logic inAck, next_inAck;
    logic ackDrive, next_ackDrive;
    logic [1:0] ptr, next_ptr;
    logic [7:0] hiByte, next_hiByte;
    logic byteIdx, next_byteIdx;
    logic dataDone, next_dataDone;
    logic masterNack, next_masterNack;
    logic [1:0] wakeSet;
    logic [15:0] readWord;
    logic writeA, writeB, clearAll, loadAll;
    ddac_word_t wordIn, inWordA, inWordB;
    logic [$clog2(PD_EXIT_CYC+1)-1:0] wakeCnt [2];
    // Keeps only the code bits that a narrow build really has
    localparam logic [15:0] LOW_MASK =
        16'hffff << (CODE_MSB_POS + 1 - CODE_W);

    ddac_cond_det u_cond (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .startSeen(startSeen),
        .stopSeen(stopSeen),
        .sclRise(sclRise),
        .sclFall(sclFall)
    );

    // Map a pointer to the readback word; unused code bits read zero
    function automatic logic [15:0] read_word(input logic [1:0] p,
                                              input ddac_word_t a,
                                              input ddac_word_t b);
        logic [15:0] w;
        w = DEFAULT_WORD;
        if (p == 2'b01)
            w = a;
        else if (p == 2'b10)
            w = b;
        w = w & LOW_MASK;
        return w;
    endfunction

    assign readWord = read_word(ptr, inWordA, inWordB);
    // Received word: mode, clear, load, left-justified code
    assign wordIn = {ddac_pmode_t'(hiByte[7:6]), hiByte[5], hiByte[4],
                     hiByte[3:0], shiftReg};
    assign writeA = dataDone && stopSeen && ptr[PTR_A_POS];
    assign writeB = dataDone && stopSeen && ptr[PTR_B_POS];
    assign clearAll = dataDone && stopSeen && !wordIn.clearAllN;
    assign loadAll = dataDone && stopSeen && !wordIn.syncLoadN;

    // Bus protocol state machine, bit counting and acknowledge
    always_comb begin
        next_state = state;
        next_shiftReg = shiftReg;
        next_bitCnt = bitCnt;
        next_inAck = inAck;
        next_ackDrive = ackDrive;
        next_ptr = ptr;
        next_hiByte = hiByte;
        next_byteIdx = byteIdx;
        next_dataDone = dataDone;
        next_masterNack = masterNack;
        wakeSet = 2'b00;
        if (startSeen) begin
            next_state = DDAC_ST_ADDR; // repeated start restarts here
            next_bitCnt = 4'h0;
            next_inAck = 1'b0;
            next_ackDrive = 1'b0;
            next_dataDone = 1'b0;
        end else if (stopSeen) begin
            next_state = DDAC_ST_IDLE;
            next_ackDrive = 1'b0;
            next_dataDone = 1'b0;
        end else if (state != DDAC_ST_IDLE && sclRise) begin
            if (inAck) begin
                next_masterNack = sdaIn;
            end else begin
                // Read bytes move on falls; a taken data word stays put
                // so the clock rise of the stop cannot corrupt it
                if (state != DDAC_ST_READ && !dataDone)
                    next_shiftReg = {shiftReg[6:0], sdaIn};
                next_bitCnt = bitCnt + 4'h1;
                if (state == DDAC_ST_DATA && byteIdx && !dataDone
                    && bitCnt == 4'h7)
                    wakeSet = ptr;
            end
        end else if (state != DDAC_ST_IDLE && sclFall) begin
            if (inAck) begin
                // Acknowledge slot ends; set up for next byte
                next_inAck = 1'b0;
                next_ackDrive = 1'b0;
                next_bitCnt = 4'h0;
                if (state == DDAC_ST_READ && masterNack)
                    next_state = DDAC_ST_DONE;
            end else if (bitCnt == 4'h8) begin
                next_inAck = 1'b1;
                case (state)
                    DDAC_ST_ADDR: begin
                        if (shiftReg[7:1] == {ADDR_UPPER, addr_select_pin})
                        begin
                            next_ackDrive = 1'b1;
                            next_byteIdx = 1'b0;
                            if (shiftReg[0]) begin
                                next_state = DDAC_ST_READ;
                                next_shiftReg = readWord[15:8];
                                next_masterNack = 1'b1;
                            end else
                                next_state = DDAC_ST_PTR;
                        end else
                            next_state = DDAC_ST_IDLE;
                    end
                    DDAC_ST_PTR: begin
                        next_ptr = {shiftReg[PTR_B_POS],
                                    shiftReg[PTR_A_POS]};
                        next_ackDrive = 1'b1;
                        next_state = DDAC_ST_DATA;
                        next_byteIdx = 1'b0;
                    end
                    DDAC_ST_DATA: begin
                        next_ackDrive = !dataDone;
                        if (!byteIdx)
                            next_hiByte = shiftReg;
                        else
                            next_dataDone = 1'b1;
                        next_byteIdx = 1'b1;
                        if (dataDone)
                            next_state = DDAC_ST_DONE;
                    end
                    DDAC_ST_READ: begin
                        // Next byte is loaded as the master's ack slot opens
                        next_ackDrive = 1'b0;
                        next_byteIdx = !byteIdx;
                        next_shiftReg = byteIdx ? readWord[15:8]
                                                : readWord[7:0];
                    end
                    default: begin
                        next_ackDrive = 1'b0;
                    end
                endcase
            end else if (state == DDAC_ST_READ && bitCnt != 4'h0) begin
                // Shift while the clock is low so data never moves high
                next_shiftReg = {shiftReg[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= DDAC_ST_IDLE;
            shiftReg <= BYTE_RESET;
            bitCnt <= 4'h0;
            inAck <= 1'b0;
            ackDrive <= 1'b0;
            ptr <= PTR_RESET;
            hiByte <= BYTE_RESET;
            byteIdx <= 1'b0;
            dataDone <= 1'b0;
            masterNack <= 1'b0;
        end else begin
            state <= next_state;
            shiftReg <= next_shiftReg;
            bitCnt <= next_bitCnt;
            inAck <= next_inAck;
            ackDrive <= next_ackDrive;
            ptr <= next_ptr;
            hiByte <= next_hiByte;
            byteIdx <= next_byteIdx;
            dataDone <= next_dataDone;
            masterNack <= next_masterNack;
        end
    end

    // Open-drain data: only ever pull low
    assign sdaOut = 1'b0;
    assign sdaOe = ackDrive || (state == DDAC_ST_READ && !inAck
                   && !shiftReg[7]);

    ddac_channel #(.CODE_W(CODE_W)) u_chan_a (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .writeEn(writeA),
        .clearAll(clearAll),
        .loadAll(loadAll),
        .wordIn(wordIn),
        .inputWord(inWordA),
        .heldCode(chanACode),
        .powerMode(chanAMode)
    );

    ddac_channel #(.CODE_W(CODE_W)) u_chan_b (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .writeEn(writeB),
        .clearAll(clearAll),
        .loadAll(loadAll),
        .wordIn(wordIn),
        .inputWord(inWordB),
        .heldCode(chanBCode),
        .powerMode(chanBMode)
    );

    // Wake timers run from the eighth clock of the last data byte
    genvar g;
    for (g = 0; g < 2; g++) begin : gen_wake
        logic [$clog2(PD_EXIT_CYC+1)-1:0] next_cnt;
        always_comb begin
            next_cnt = wakeCnt[g];
            if (wakeSet[g] && wordIn.mode == DDAC_PM_NORMAL)
                next_cnt = ($clog2(PD_EXIT_CYC+1))'(PD_EXIT_CYC);
            else if (wakeCnt[g] != '0)
                next_cnt = wakeCnt[g] - 1'b1;
        end
        always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst)
                wakeCnt[g] <= '0;
            else
                wakeCnt[g] <= next_cnt;
        end
    end
    assign chanAWaking = wakeCnt[0] != '0;
    assign chanBWaking = wakeCnt[1] != '0;

    // Checks
    property p_clear;
        @(posedge core_clk) disable iff (sys_rst)
        clearAll |=> (chanACode == '0 && chanBCode == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");
    property p_hold;
        @(posedge core_clk) disable iff (sys_rst)
        !loadAll && !clearAll |=> $stable(chanACode);
    endproperty
    a_hold: assert property (p_hold) else $error("code moved");
    property p_both;
        @(posedge core_clk) disable iff (sys_rst)
        writeA && writeB && wordIn.clearAllN |=> inWordA == inWordB;
    endproperty
    a_both: assert property (p_both) else $error("dual write");
    property p_mode;
        @(posedge core_clk) disable iff (sys_rst)
        writeA && !clearAll |=> chanAMode == $past(wordIn.mode);
    endproperty
    a_mode: assert property (p_mode) else $error("mode");
    property p_def;
        @(posedge core_clk) disable iff (sys_rst)
        ptr == 2'b11 || ptr == 2'b00 |-> readWord == DEFAULT_WORD;
    endproperty
    a_def: assert property (p_def) else $error("default word");
    property p_zero;
        @(posedge core_clk) disable iff (sys_rst)
        (readWord & ~LOW_MASK) == 16'h0;
    endproperty
    a_zero: assert property (p_zero) else $error("low bits");
    property p_noack;
        @(posedge core_clk) disable iff (sys_rst)
        state == DDAC_ST_IDLE && !startSeen |=> !ackDrive;
    endproperty
    a_noack: assert property (p_noack) else $error("stray ack");
    property p_wake;
        @(posedge core_clk) disable iff (sys_rst)
        $rose(chanAWaking) |-> chanAWaking [*8];
    endproperty
    a_wake: assert property (p_wake) else $error("wake short");
    c_write: cover property (@(posedge core_clk) writeA);
    c_load: cover property (@(posedge core_clk) loadAll);
    c_read: cover property (@(posedge core_clk) state == DDAC_ST_READ);
endmodule

// *** sim/ddac_bus_master.sv ***
// Bus master model that drives clock and data toward the slave
module ddac_bus_master (
    input wire logic core_clk,
    input wire logic sdaLine,
    output logic scl,
    output logic sdaDrv,
    output logic resValid,
    output logic [31:0] resVal
);
    timeunit 1ns;
    timeprecision 1ns;

    // Cycles per wait step (a bit is three steps plus one cycle); the bench raises it to act as a slow master
    int phase = 4;

    // Idle bus: clock high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
        resValid = 1'b0;
        resVal = 32'h0;
    end

    task automatic waitPhase();
        repeat (phase) @(posedge core_clk);
    endtask

    // Data moves mid low phase; line read half a cycle before clock falls
    task automatic bitXfer(input logic v, output logic s);
        scl <= 1'b0;
        waitPhase();
        sdaDrv <= v;
        waitPhase();
        scl <= 1'b1;
        waitPhase();
        @(negedge core_clk);
        s = sdaLine;
        @(posedge core_clk);
    endtask

    // Hands one result to the bench monitor
    task automatic report(input logic [31:0] v);
        resVal <= v;
        resValid <= 1'b1;
        @(posedge core_clk);
        resValid <= 1'b0;
    endtask

    // Clock is lowered first so a held acknowledge cannot mask the start
    task automatic start();
        scl <= 1'b0;
        waitPhase();
        sdaDrv <= 1'b1;
        waitPhase();
        scl <= 1'b1;
        waitPhase();
        sdaDrv <= 1'b0;
        waitPhase();
    endtask

    task automatic stop();
        scl <= 1'b0;
        waitPhase();
        sdaDrv <= 1'b0;
        waitPhase();
        scl <= 1'b1;
        waitPhase();
        sdaDrv <= 1'b1;
        waitPhase();
    endtask

    task automatic wrByte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bitXfer(b[i], s);
        bitXfer(1'b1, s);
        report({31'h0, s});
    endtask

    // Low on the ninth bit asks the slave to keep sending
    task automatic rdByte(input logic nak);
        logic s;
        logic [7:0] b;
        for (int i = 7; i >= 0; i--) begin
            bitXfer(1'b1, s);
            b[i] = s;
        end
        bitXfer(nak, s);
        report({24'h0, b});
    endtask
endmodule

// *** sim/ddac_slave_tb.sv ***
// Self-checking bench for the dual DAC two-wire slave
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errCount++; \
    $display("unexpected at %0t got %h expected %h", $time, g, e); end end

module ddac_slave_tb
    import ddac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CW = 10;
    localparam logic [15:0] MASK = 16'hfffc;
    logic core_clk, sys_rst, sclIn, sdaDrv, sdaOut, sdaOe, addrSel, snapReq;
    logic resValid, wakeA, wakeB;
    logic [31:0] resVal, got, exp, seed = 32'h5935;
    logic [CW-1:0] codeA, codeB, dac[2];
    ddac_pmode_t modeA, modeB;
    logic [15:0] inReg[2];
    logic [1:0] mode[2], curPtr;
    logic written[2];
    logic [6:0] devAddr;
    logic [31:0] q[$];
    int errCount = 0, nTests = 0;
    wire logic line = sdaDrv & ~(sdaOe & ~sdaOut);
    wire logic [31:0] snapVec = {6'h0, codeA, codeB, modeA, modeB, wakeA, wakeB};

    ddac_slave #(.CODE_W(CW)) ddac_slave_i (.core_clk(core_clk),
        .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(line), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .addr_select_pin(addrSel), .chanACode(codeA),
        .chanBCode(codeB), .chanAMode(modeA), .chanBMode(modeB),
        .chanAWaking(wakeA), .chanBWaking(wakeB));
    ddac_bus_master ddac_bus_master_i (.core_clk(core_clk), .sdaLine(line),
        .scl(sclIn), .sdaDrv(sdaDrv), .resValid(resValid), .resVal(resVal));

    // Free-running 20 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    function automatic logic [11:0] nextRand();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[11:0];
    endfunction

    // Pointer 00 and 11 both give the power-on word
    function automatic logic [15:0] rbWord(input logic [1:0] p);
        if (p == 2'h1) return inReg[0];
        if (p == 2'h2) return inReg[1];
        return 16'h2000;
    endfunction

    task automatic note(input logic [31:0] v);
        q.push_back(v);
    endtask

    task automatic summarize();
        `CHK(q.size(), 0)
        if (errCount == 0 && nTests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Reference model of the double-buffered registers
    task automatic applyWrite(input logic [1:0] p, input logic [15:0] w);
        for (int c = 0; c < 2; c++) begin
            if (!w[13]) begin
                inReg[c] = 16'h3000;
                dac[c] = '0;
                written[c] = 1'b0;
            end else begin
                if (p[c]) begin
                    inReg[c] = w & MASK;
                    mode[c] = w[15:14];
                    written[c] = 1'b1;
                end
                if (!w[12] && written[c]) begin
                    dac[c] = inReg[c][11 -: CW];
                    written[c] = 1'b0;
                end
            end
        end
    endtask

    task automatic sendHead(input logic rw, input logic [6:0] a,
                            input logic ack);
        ddac_bus_master_i.start();
        note({31'h0, ack});
        ddac_bus_master_i.wrByte({a, rw});
    endtask

    // Address, pointer, then either zero, one or two data bytes
    task automatic writeSeq(input logic [7:0] p, input logic [15:0] w,
                            input int nb);
        sendHead(1'b0, devAddr, 1'b0);
        note(32'h0);
        ddac_bus_master_i.wrByte(p);
        curPtr = p[1:0];
        for (int i = 0; i < nb; i++) begin
            note(32'h0);
            ddac_bus_master_i.wrByte(i == 0 ? w[15:8] : w[7:0]);
        end
    endtask

    task automatic writeWord(input logic [7:0] p, input logic [15:0] w);
        writeSeq(p, w, 2);
        ddac_bus_master_i.stop();
        applyWrite(p[1:0], w);
    endtask

    task automatic readWords(input logic ptrGiven, input logic [7:0] p,
                             input int n);
        logic [15:0] w;
        if (ptrGiven) writeSeq(p, 16'h0, 0);
        w = rbWord(curPtr);
        sendHead(1'b1, devAddr, 1'b0);
        for (int k = 0; k < n; k++) begin
            note({24'h0, w[15:8]});
            ddac_bus_master_i.rdByte(1'b0);
            note({24'h0, w[7:0]});
            ddac_bus_master_i.rdByte(k == n - 1);
        end
        ddac_bus_master_i.stop();
    endtask

    task automatic snap(input int n, input logic wa, input logic wb);
        repeat (n) @(posedge core_clk);
        note({6'h0, dac[0], dac[1], mode[0], mode[1], wa, wb});
        snapReq <= 1'b1;
        @(posedge core_clk);
        snapReq <= 1'b0;
    endtask

    // Monitor: each reported result is matched to the oldest note
    always @(posedge core_clk) begin
        if (resValid === 1'b1 || snapReq === 1'b1) begin
            got = resValid ? resVal : snapVec;
            exp = (q.size() > 0) ? q.pop_front() : 32'hdeadbeef;
            `CHK(got, exp)
        end
    end

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        snapReq = 1'b0;
        addrSel = 1'b0;
        curPtr = 2'h0;
        for (int c = 0; c < 2; c++) begin
            inReg[c] = 16'h0;
            dac[c] = '0;
            mode[c] = 2'h0;
            written[c] = 1'b0;
        end
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        snap(2, 1'b0, 1'b0);
        devAddr = {ADDR_UPPER, 1'b0};
        readWords(1'b0, 8'h0, 1);
        sendHead(1'b0, {ADDR_UPPER, 1'b1}, 1'b1);
        ddac_bus_master_i.stop();
        sendHead(1'b0, 7'h2c, 1'b1);
        ddac_bus_master_i.stop();
        addrSel <= 1'b1;
        devAddr = {ADDR_UPPER, 1'b1};
        writeWord(8'h01, {4'h3, nextRand()});
        snap(60, 1'b0, 1'b0);
        readWords(1'b1, 8'hc1, 2);
        ddac_bus_master_i.phase = 7;
        writeWord(8'h02, {4'h2, nextRand()});
        ddac_bus_master_i.phase = 4;
        snap(60, 1'b0, 1'b0);
        writeWord(8'h03, {4'h2, nextRand()});
        snap(60, 1'b0, 1'b0);
        readWords(1'b0, 8'h0, 1);
        writeWord(8'h02, {4'h3, nextRand()});
        readWords(1'b0, 8'h0, 1);
        for (int m = 0; m < 4; m++) begin
            writeWord(8'h01, {m[1:0], 2'h3, nextRand()});
            snap(60, 1'b0, 1'b0);
        end
        writeWord(8'h03, {4'h3, nextRand()});
        snap(0, 1'b1, 1'b1);
        snap(60, 1'b0, 1'b0);
        writeSeq(8'h02, {4'h2, nextRand()}, 1);
        ddac_bus_master_i.stop();
        snap(60, 1'b0, 1'b0);
        readWords(1'b1, 8'h02, 1);
        writeWord(8'h01, 16'h1000);
        snap(60, 1'b0, 1'b0);
        readWords(1'b1, 8'h02, 1);
        writeSeq(8'h01, {4'h3, nextRand()}, 2);
        note(32'h1);
        ddac_bus_master_i.wrByte(8'h5a);
        ddac_bus_master_i.stop();
        repeat (4) @(posedge core_clk);
        summarize();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge core_clk);
        errCount++;
        summarize();
    end
endmodule
